// ===== src/wdft_dev.sv
//-----------------------------------------------------------------------------
// Purpose: watchdog timer and instruction-fetch trap unit
// Assumes: link inputs come from logic on the same clock
// Notes:   control registers are write-only; state shows on user outputs
//-----------------------------------------------------------------------------
// Summary of operation
// RULE1: enable bit resets to 1; writing 1 enables
// RULE2: software disables via flag, clear, bit, code
// RULE3: disable code accepted only with enable bit 0
// RULE4: binary counter held cleared while disabled
// RULE5: clear code resets binary counter, not divider
// RULE6: period field selects 2^25..2^19 or 2^17..2^11
// RULE7: action bit 0 gives overflow interrupt
// RULE8: action bit cleared stays cleared until reset
// RULE9: overflow interrupt ignores global enable flag
// RULE10: new overflow interrupt nests over any service
// RULE11: software avoids endless nesting without return
// RULE12: stack pointer set before overflow interrupt mode
// RULE13: action bit 1 gives reset on overflow
// RULE14: internal reset lasts at most 24 periods
// RULE15: low-speed reset restarts oscillator, timed high-speed
// RULE16: ram trap bit takes effect after D2 code
// RULE17: register and buffer area fetches always trap
// RULE18: trap action bit 0 gives trap interrupt
// RULE19: trap action bit 1 gives reset
// RULE20: trap interrupt ignores global enable flag
// RULE21: new trap interrupt nests over any service
// RULE22: stack pointer set before trap interrupts
// RULE23: watchdog and trap fields share both registers
// RULE24: each event is a one-cycle request pulse
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
module wdft_dev
  import wdft_pkg::*;
#(
  parameter int          HS_EXP  = HS_LONG_EXP,
  parameter int          LS_EXP  = LS_LONG_EXP,
  parameter logic [15:0] SFR_LO  = 16'h0000,
  parameter logic [15:0] SFR_HI  = 16'h003F,
  parameter logic [15:0] RAM_LO  = 16'h0040,
  parameter logic [15:0] RAM_HI  = 16'h083F,
  parameter logic [15:0] DBR_LO  = 16'h0F80,
  parameter logic [15:0] DBR_HI  = 16'h0FFF
) (
  input  wire logic  CLK_IN,
  input  wire logic  ARST_N_IN,
  wdft_if.dev        LINK,
  output logic       RUNNING_OUT,
  output logic       RAM_TRAP_ARMED_OUT,
  output logic [1:0] BIN_COUNT_OUT
);

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [DIV_W-1:0] low_mask(input int unsigned t);
    logic [63:0] m;
    m = (64'd1 << t) - 64'd1;
    low_mask = m[DIV_W-1:0];
  endfunction : low_mask

  function automatic logic in_area(input logic [15:0] a,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
    in_area = (a >= lo) && (a <= hi);
  endfunction : in_area

  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  logic [7:0]       ctl1_r;
  logic             run_r;
  logic             ram_trap_r;
  logic [DIV_W-1:0] div_r;
  logic [1:0]       bin_r;
  logic             ovf_nmi_r;
  logic             trap_nmi_r;
  logic             rst_req_r;
  logic             osc_r;
  wdft_rst_state_t  rst_state_r;
  logic [7:0]       hold_cnt_r;

  logic             sys_rst;
  logic             wr_one;
  logic             wr_code;
  logic             code_clear;
  logic             code_disable;
  logic             code_commit;
  logic             div_step;
  int unsigned      tap;
  logic [DIV_W-1:0] tap_m;
  logic             tick;
  logic             ovf;
  logic             hit;

  // ---------------------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------------------
  // internal reset re-initialises the unit, all but the divider, while it is held
  assign sys_rst      = (rst_state_r == RS_HOLD);
  // both registers carry watchdog and trap fields together
  assign wr_one       = LINK.wr_stb && !LINK.wr_sel;                // RULE23
  assign wr_code      = LINK.wr_stb && LINK.wr_sel;                 // RULE23
  assign code_clear   = wr_code && (LINK.wr_data == CODE_CLEAR);
  assign code_disable = wr_code && (LINK.wr_data == CODE_DISABLE);
  assign code_commit  = wr_code && (LINK.wr_data == CODE_COMMIT);

  // ---------------------------------------------------------------------------
  // control register one
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ctl1_r <= CTL1_RESET;                                         // RULE1
    end else if (sys_rst) begin
      ctl1_r <= CTL1_RESET;
    end else if (wr_one) begin
      ctl1_r <= {2'b00, LINK.wr_data[5:1],
                 LINK.wr_data[BIT_OVF_ACT] & ctl1_r[BIT_OVF_ACT]};  // RULE8
    end
  end

  // ---------------------------------------------------------------------------
  // run state: enable by bit, disable by code
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      run_r <= 1'b1;                                                // RULE1
    end else if (sys_rst) begin
      run_r <= 1'b1;
    end else if (wr_one && LINK.wr_data[BIT_EN]) begin
      run_r <= 1'b1;                                                // RULE1
    end else if (code_disable && !ctl1_r[BIT_EN]) begin
      run_r <= 1'b0;                                                // RULE3
    end
  end

  // ---------------------------------------------------------------------------
  // effective ram trap selection
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ram_trap_r <= CTL1_RESET[BIT_RAM_TRAP];
    end else if (sys_rst) begin
      ram_trap_r <= CTL1_RESET[BIT_RAM_TRAP];
    end else if (code_commit) begin
      ram_trap_r <= ctl1_r[BIT_RAM_TRAP];                           // RULE16
    end
  end

  // ---------------------------------------------------------------------------
  // divider and tap selection
  // ---------------------------------------------------------------------------
  // divider runs on every hs clock, or on ls ticks in low-speed mode
  assign div_step = LINK.low_speed_mode_one ? LINK.ls_tick : 1'b1;

  // binary counter is two stages, so its tick is a quarter of the period
  always_comb begin
    if (LINK.low_speed_mode_one) begin
      tap = unsigned'(LS_EXP - 2 - 2 * int'(ctl1_r[BIT_PER_HI:BIT_PER_LO]));   // RULE6
    end else begin
      tap = unsigned'(HS_EXP - 2 - 2 * int'(ctl1_r[BIT_PER_HI:BIT_PER_LO]));   // RULE6
    end
  end

  assign tap_m = low_mask(tap);
  assign tick  = div_step && ((div_r & tap_m) == tap_m);

  // never cleared by the code port
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      div_r <= '0;
    end else if (div_step) begin
      div_r <= div_r + DIV_W'(1);                                   // RULE5
    end
  end

  // ---------------------------------------------------------------------------
  // binary counter
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      bin_r <= 2'b00;
    end else if (!run_r || sys_rst) begin
      bin_r <= 2'b00;                                               // RULE4
    end else if (code_clear) begin
      bin_r <= 2'b00;                                               // RULE5
    end else if (tick) begin
      bin_r <= bin_r + 2'b01;
    end
  end

  // clear in the same cycle beats the overflow
  assign ovf = run_r && !sys_rst && !code_clear && tick && (bin_r == 2'b11);

  // ---------------------------------------------------------------------------
  // fetch trap detection
  // ---------------------------------------------------------------------------
  assign hit = LINK.fetch_stb && !sys_rst &&
               (in_area(LINK.fetch_addr, SFR_LO, SFR_HI) ||
                in_area(LINK.fetch_addr, DBR_LO, DBR_HI) ||               // RULE17
                (ram_trap_r && in_area(LINK.fetch_addr, RAM_LO, RAM_HI))); // RULE16

  // ---------------------------------------------------------------------------
  // event pulses
  // ---------------------------------------------------------------------------
  // no mask input exists: requests go out whatever the global flag
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ovf_nmi_r  <= 1'b0;
      trap_nmi_r <= 1'b0;
    end else begin
      ovf_nmi_r  <= ovf && !ctl1_r[BIT_OVF_ACT];   // RULE7 RULE9 RULE10 RULE24
      trap_nmi_r <= hit && !ctl1_r[BIT_TRAP_ACT];  // RULE18 RULE20 RULE21 RULE24
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rst_req_r <= 1'b0;
      osc_r     <= 1'b0;
    end else begin
      rst_req_r <= (ovf && ctl1_r[BIT_OVF_ACT]) ||                  // RULE13 RULE24
                   (hit && ctl1_r[BIT_TRAP_ACT]);                   // RULE19
      osc_r     <= ((ovf && ctl1_r[BIT_OVF_ACT]) || (hit && ctl1_r[BIT_TRAP_ACT])) &&
                   LINK.low_speed_mode_one;                         // RULE15
    end
  end

  // ---------------------------------------------------------------------------
  // internal reset sequencer
  // ---------------------------------------------------------------------------
  // timed on the hs clock also in low-speed mode
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rst_state_r <= RS_IDLE;
      hold_cnt_r  <= 8'h00;
    end else begin
      case (rst_state_r)
        RS_IDLE: begin
          if (rst_req_r) begin
            rst_state_r <= RS_HOLD;
            hold_cnt_r  <= 8'(RST_CYC - 1);                         // RULE14 RULE15
          end
        end
        RS_HOLD: begin
          if (hold_cnt_r == 8'h00) begin
            rst_state_r <= RS_IDLE;
          end else begin
            hold_cnt_r <= hold_cnt_r - 8'h01;
          end
        end
        default: begin
          rst_state_r <= RS_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign LINK.overflow_nmi   = ovf_nmi_r;
  assign LINK.fetch_trap_nmi = trap_nmi_r;
  assign LINK.rst_req        = rst_req_r;
  assign LINK.hw_rst         = sys_rst;
  assign LINK.osc_restart    = osc_r;
  assign RUNNING_OUT         = run_r;
  assign RAM_TRAP_ARMED_OUT  = ram_trap_r;
  assign BIN_COUNT_OUT       = bin_r;

endmodule : wdft_dev

// ===== src/wdft_pkg.sv
//-----------------------------------------------------------------------------
// Purpose: constants and types shared by the watchdog/fetch-trap unit ends
// Assumes: one 40 MHz system clock, which is also the high-speed clock
// Notes:   all offsets, codes, reset values and cycle counts live here
//-----------------------------------------------------------------------------
package wdft_pkg;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int RST_TIME_PS   = 600000;                      // 24 high-speed periods
  localparam int RST_CYC       = RST_TIME_PS / CLK_PERIOD_PS; // longest time, rounded down
  localparam int LS_PERIOD_PS  = 30517578;                    // 32.768 kHz low-speed clock
  localparam int LS_DIV_CYC    = LS_PERIOD_PS / CLK_PERIOD_PS;
  localparam int HS_LONG_EXP   = 25;                          // longest period 2^25 hs cycles
  localparam int LS_LONG_EXP   = 17;                          // longest period 2^17 ls cycles
  localparam int DIV_W         = 24;

  // ---------------------------------------------------------------------------
  // control register one: fields and value after reset
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CTL1_RESET   = 8'h39;
  localparam int         BIT_OVF_ACT  = 0;
  localparam int         BIT_PER_LO   = 1;
  localparam int         BIT_PER_HI   = 2;
  localparam int         BIT_EN       = 3;
  localparam int         BIT_TRAP_ACT = 4;
  localparam int         BIT_RAM_TRAP = 5;

  // ---------------------------------------------------------------------------
  // code port values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CODE_CLEAR   = 8'h4E;
  localparam logic [7:0] CODE_DISABLE = 8'hB1;
  localparam logic [7:0] CODE_COMMIT  = 8'hD2;

  // ---------------------------------------------------------------------------
  // controller APB map and status fields
  // ---------------------------------------------------------------------------
  localparam logic [7:0] A_CMD   = 8'h00;
  localparam logic [7:0] A_FETCH = 8'h04;
  localparam logic [7:0] A_STAT  = 8'h08;
  localparam logic [7:0] A_IRQEN = 8'h0C;
  localparam logic [7:0] A_NMI_RETURN_INSTR  = 8'h10;
  localparam logic [7:0] A_MODE  = 8'h14;
  localparam logic [7:0] A_SP    = 8'h18;
  localparam int         CMD_SEL_BIT = 8;
  localparam int         ST_STICKY_LO = 8;
  localparam int         ST_STICKY_W  = 7;
  localparam int         ST_LIVE_RST  = 15;

  typedef enum logic [1:0] {
    RS_IDLE = 2'b00,
    RS_HOLD = 2'b01
  } wdft_rst_state_t;

endpackage : wdft_pkg

// ===== src/wdft_if.sv
//-----------------------------------------------------------------------------
// Purpose: link between the watchdog/fetch-trap unit and its cpu-side party
// Assumes: both ends run on the same system clock
// Notes:   strobes and event outputs are one-cycle pulses
//-----------------------------------------------------------------------------
`timescale 1ns/100ps
interface wdft_if;
  logic        wr_stb;         // register write strobe
  logic        wr_sel;         // 0 control one, 1 code port
  logic [7:0]  wr_data;
  logic        fetch_stb;      // instruction fetch
  logic [15:0] fetch_addr;
  logic        low_speed_mode_one;
  logic        ls_tick;        // one pulse per low-speed clock period
  logic        overflow_nmi;
  logic        fetch_trap_nmi;
  logic        rst_req;
  logic        hw_rst;         // internal hardware reset level
  logic        osc_restart;

  modport dev (
    input  wr_stb, wr_sel, wr_data, fetch_stb, fetch_addr, low_speed_mode_one, ls_tick,
    output overflow_nmi, fetch_trap_nmi, rst_req, hw_rst, osc_restart
  );
  modport ctl (
    output wr_stb, wr_sel, wr_data, fetch_stb, fetch_addr, low_speed_mode_one, ls_tick,
    input  overflow_nmi, fetch_trap_nmi, rst_req, hw_rst, osc_restart
  );
endinterface : wdft_if

// ===== src/wdft_ctl.sv
//-----------------------------------------------------------------------------
// Purpose: cpu-side party: APB orders, nmi nesting and reset bookkeeping
// Assumes: APB master on the same clock; zero-wait access phase
// Notes:   sticky status bits clear by writing 1; a set wins over a clear
//-----------------------------------------------------------------------------
`timescale 1ns/100ps
module wdft_ctl
  import wdft_pkg::*;
(
  input  wire logic        CLK_IN,
  input  wire logic        ARST_N_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic [31:0]      PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  output logic             NMI_TAKEN_OUT,
  output logic             SYS_RESET_OUT,
  wdft_if.ctl              LINK
);

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == A_CMD) || (a == A_FETCH) || (a == A_STAT) || (a == A_IRQEN) ||
             (a == A_NMI_RETURN_INSTR) || (a == A_MODE) || (a == A_SP);
  endfunction : mapped

  logic        wr_stb_r, wr_sel_r, fetch_stb_r, low_r, irq_en_r, sp_ok_r, nmi_r;
  logic [7:0]  wr_data_r;
  logic [15:0] fetch_addr_r;
  logic [7:0]  depth_r;
  logic [ST_STICKY_W-1:0] sticky_r, sticky_set;
  logic [10:0] ls_cnt_r;
  logic [31:0] rd_r;
  logic        acc, wr, nmi, refuse;

  // ---------------------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------------------
  assign acc         = PSEL_IN && PENABLE_IN;
  assign wr          = acc && PWRITE_IN && mapped(PADDR_IN);
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = acc && !mapped(PADDR_IN);
  assign PRDATA_OUT  = rd_r;

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rd_r <= 32'h0000_0000;
    end else if (PSEL_IN && !PENABLE_IN) begin
      if (PADDR_IN == A_STAT) begin
        rd_r <= {16'h0000, LINK.hw_rst, sticky_r, depth_r};
      end else if (PADDR_IN == A_IRQEN) begin
        rd_r <= {31'h0000_0000, irq_en_r};
      end else if (PADDR_IN == A_MODE) begin
        rd_r <= {31'h0000_0000, low_r};
      end else if (PADDR_IN == A_SP) begin
        rd_r <= {31'h0000_0000, sp_ok_r};
      end else begin
        rd_r <= 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // orders to the unit
  // ---------------------------------------------------------------------------
  // disable code refused while the global flag is still set
  assign refuse = wr && (PADDR_IN == A_CMD) && PWDATA_IN[CMD_SEL_BIT] &&
                  (PWDATA_IN[7:0] == CODE_DISABLE) && irq_en_r;              // RULE2

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      wr_stb_r     <= 1'b0;
      wr_sel_r     <= 1'b0;
      wr_data_r    <= 8'h00;
      fetch_stb_r  <= 1'b0;
      fetch_addr_r <= 16'h0000;
    end else begin
      wr_stb_r    <= wr && (PADDR_IN == A_CMD) && !refuse;
      fetch_stb_r <= wr && (PADDR_IN == A_FETCH);
      if (wr && (PADDR_IN == A_CMD)) begin
        wr_sel_r  <= PWDATA_IN[CMD_SEL_BIT];
        wr_data_r <= PWDATA_IN[7:0];
      end
      if (wr && (PADDR_IN == A_FETCH)) begin
        fetch_addr_r <= PWDATA_IN[15:0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // mode, global flag, stack, low-speed tick
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      low_r    <= 1'b0;
      irq_en_r <= 1'b0;
      sp_ok_r  <= 1'b0;
    end else if (LINK.hw_rst) begin
      low_r    <= 1'b0;
      irq_en_r <= 1'b0;
      sp_ok_r  <= 1'b0;
    end else begin
      if (wr && (PADDR_IN == A_MODE)) low_r <= PWDATA_IN[0];
      if (wr && (PADDR_IN == A_IRQEN)) irq_en_r <= PWDATA_IN[0];
      if (wr && (PADDR_IN == A_SP)) sp_ok_r <= 1'b1;
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ls_cnt_r <= 11'h000;
    end else if (ls_cnt_r == 11'(LS_DIV_CYC - 1)) begin
      ls_cnt_r <= 11'h000;
    end else begin
      ls_cnt_r <= ls_cnt_r + 11'h001;
    end
  end

  // ---------------------------------------------------------------------------
  // nmi acceptance and nesting
  // ---------------------------------------------------------------------------
  // accepted regardless of irq_en_r; each request cycle nests on the current service until depth 255
  assign nmi = LINK.overflow_nmi || LINK.fetch_trap_nmi;             // RULE9 RULE20

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      depth_r <= 8'h00;
      nmi_r   <= 1'b0;
    end else begin
      nmi_r <= nmi;
      if (LINK.hw_rst) begin
        depth_r <= 8'h00;
      end else if (nmi && !(wr && (PADDR_IN == A_NMI_RETURN_INSTR)) && (depth_r != 8'hFF)) begin
        depth_r <= depth_r + 8'h01;                                  // RULE10 RULE21
      end else if (!nmi && wr && (PADDR_IN == A_NMI_RETURN_INSTR) && (depth_r != 8'h00)) begin
        depth_r <= depth_r - 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // sticky status
  // ---------------------------------------------------------------------------
  // ovf, trap, reset, nmi without stack, deep nesting, refused disable
  assign sticky_set = {1'b0, refuse,
                       nmi && (depth_r >= 8'hFE),                    // RULE11
                       nmi && !sp_ok_r,                              // RULE12 RULE22
                       LINK.rst_req, LINK.fetch_trap_nmi, LINK.overflow_nmi};

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      sticky_r <= '0;
    end else if (wr && (PADDR_IN == A_STAT)) begin
      sticky_r <= (sticky_r & ~PWDATA_IN[ST_STICKY_LO +: ST_STICKY_W]) | sticky_set;
    end else begin
      sticky_r <= sticky_r | sticky_set;
    end
  end

  // ---------------------------------------------------------------------------
  // link outputs
  // ---------------------------------------------------------------------------
  assign LINK.wr_stb             = wr_stb_r;
  assign LINK.wr_sel             = wr_sel_r;
  assign LINK.wr_data            = wr_data_r;
  assign LINK.fetch_stb          = fetch_stb_r;
  assign LINK.fetch_addr         = fetch_addr_r;
  assign LINK.low_speed_mode_one = low_r;
  assign LINK.ls_tick            = (ls_cnt_r == 11'(LS_DIV_CYC - 1));
  assign NMI_TAKEN_OUT           = nmi_r;
  assign SYS_RESET_OUT           = LINK.hw_rst;

endmodule : wdft_ctl

// ===== test/wdft_checker.sv
// Purpose: assertions on the dev-ctl link
// Assumes: one clock domain
// Notes:   area bounds are the dev defaults
`timescale 1ns/100ps
module wdft_checker (
  input wire logic        CLK_IN,
  input wire logic        ARST_N_IN,
  input wire logic        fetch_stb,
  input wire logic [15:0] fetch_addr,
  input wire logic        overflow_nmi,
  input wire logic        fetch_trap_nmi,
  input wire logic        rst_req,
  input wire logic        hw_rst,
  input wire logic        osc_restart
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  logic trap_area;
  assign trap_area = fetch_addr <= 16'h003F || fetch_addr >= 16'h0F80 && fetch_addr <= 16'h0FFF;
  sequence s_hold;
    hw_rst[*8] ##1 hw_rst[*8] ##1 hw_rst[*8] ##1 !hw_rst;
  endsequence
  AST_TRAP_PULSE: assert property (fetch_trap_nmi |=> !fetch_trap_nmi)
    else $error("trap pulse too long");
  AST_OVF_PULSE: assert property (overflow_nmi |=> !overflow_nmi)
    else $error("overflow pulse too long");
  AST_RST_HOLD: assert property (rst_req |=> s_hold)
    else $error("reset hold wrong");
  AST_RST_CAUSE: assert property ($rose(hw_rst) |-> $past(rst_req))
    else $error("reset without request");
  AST_AREA_TRAP: assert property (fetch_stb && trap_area && !hw_rst && !rst_req
    |=> fetch_trap_nmi || rst_req) else $error("area fetch not trapped");
  AST_NO_TRAP: assert property (fetch_stb && fetch_addr >= 16'h1000 |=> !fetch_trap_nmi)
    else $error("trap outside areas");
  AST_OSC: assert property (osc_restart |-> rst_req)
    else $error("restart without reset");
  AST_QUIET: assert property (hw_rst && $past(hw_rst) |-> !(overflow_nmi || fetch_trap_nmi || rst_req))
    else $error("event during reset");
endmodule : wdft_checker

// ===== test/test_watchdog_and_fetch_trap.sv
// Purpose: bench for the watchdog/fetch-trap pair
// Assumes: shortened periods, HS_EXP 9
// Notes:   link events counted by a monitor
`timescale 1ns/100ps
module test_watchdog_and_fetch_trap
  import wdft_pkg::*;
;
  logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, slverr, pready, er, run, armed;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [1:0]  bin;
  logic        srst;
  int          num_errors = 0, num_checks = 0, n_ovf = 0, n_trap = 0, n_rst = 0, n_osc = 0, b;
  logic [15:0] row_a [9] = '{16'h0000, 16'h003F, 16'h0040, 16'h083F, 16'h0840, 16'h0F7F,
                             16'h0F80, 16'h0FFF, 16'h1000};
  logic [31:0] row_t [9] = '{1, 1, 1, 1, 0, 0, 1, 1, 0};
  wdft_if lnk ();
  wdft_dev #(.HS_EXP(9), .LS_EXP(9)) i_wdft_dev (.CLK_IN(clk), .ARST_N_IN(rst_n), .LINK(lnk),
    .RUNNING_OUT(run), .RAM_TRAP_ARMED_OUT(armed), .BIN_COUNT_OUT(bin));
  wdft_ctl i_wdft_ctl (.CLK_IN(clk), .ARST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(slverr), .NMI_TAKEN_OUT(), .SYS_RESET_OUT(srst), .LINK(lnk));
  wdft_checker i_wdft_checker (.CLK_IN(clk), .ARST_N_IN(rst_n), .fetch_stb(lnk.fetch_stb),
    .fetch_addr(lnk.fetch_addr), .overflow_nmi(lnk.overflow_nmi), .rst_req(lnk.rst_req),
    .fetch_trap_nmi(lnk.fetch_trap_nmi), .hw_rst(lnk.hw_rst), .osc_restart(lnk.osc_restart));
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    n_ovf  <= n_ovf + int'(lnk.overflow_nmi);
    n_trap <= n_trap + int'(lnk.fetch_trap_nmi);
    n_rst  <= n_rst + int'(lnk.rst_req);
    n_osc  <= n_osc + int'(lnk.osc_restart);
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = slverr;
    psel <= 0;
    pen  <= 0;
  endtask : apb
  task automatic cmd(input logic s, input logic [7:0] v);
    apb(1, A_CMD, {23'h0, s, v});
  endtask : cmd
  task automatic fetch(input logic [15:0] a, input logic [31:0] e);
    int s;
    s = n_trap;
    apb(1, A_FETCH, {16'h0, a});
    repeat (4) @(posedge clk);
    chk("trap", n_trap - s, e);
  endtask : fetch
  task automatic wait_ev(ref int c, input int lim);
    int s;
    s = c;
    repeat (lim) if (c == s) @(posedge clk);
  endtask : wait_ev
  task automatic tally_and_finish();
    if (num_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (10000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    chk("armed", armed, 1);
    cmd(1, CODE_DISABLE);
    repeat (2) @(posedge clk);
    chk("run", run, 1);
    cmd(1, CODE_CLEAR);
    cmd(0, 8'h20);
    cmd(1, CODE_DISABLE);
    cmd(1, CODE_COMMIT);
    repeat (600) @(posedge clk);
    chk("run", run, 0);
    chk("bin", bin, 0);
    for (int i = 0; i < 9; i++) fetch(row_a[i], row_t[i]);
    cmd(0, 8'h00);
    fetch(16'h0040, 1);
    cmd(1, CODE_COMMIT);
    repeat (2) @(posedge clk);
    chk("armed", armed, 0);
    fetch(16'h0040, 0);
    apb(1, A_IRQEN, 1);
    cmd(1, CODE_DISABLE);
    b = n_ovf;
    cmd(0, 8'h0E);
    wait_ev(n_ovf, 200);
    chk("ovf", n_ovf - b, 1);
    apb(0, A_STAT, 0);
    chk("ovf_seen", rd[8], 1);
    chk("refused", rd[13], 1);
    cmd(0, 8'h0F);
    b = n_rst;
    wait_ev(n_ovf, 200);
    chk("rst", n_rst - b, 0);
    apb(1, 8'h40, 0);
    chk("slverr", er, 1);
    apb(1, A_MODE, 1);
    cmd(0, 8'h10);
    b = n_osc;
    fetch(16'h0000, 0);
    chk("osc", n_osc - b, 1);
    chk("srst", srst, 1);
    repeat (30) @(posedge clk);
    chk("run", run, 1);
    chk("armed", armed, 1);
    b = n_rst;
    wait_ev(n_rst, 1500);
    chk("wdrst", n_rst - b, 1);
    tally_and_finish();
  end
endmodule : test_watchdog_and_fetch_trap
